// >>> design/abg_ground_ctrl.sv
// Design decision made here: the AXI4-Lite slave port.
`default_nettype none

module abg_ground_ctrl
  import abg_pkg::*;
(
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  input  wire logic [31:0]            s_axi_awaddr_i,
  input  wire logic                   s_axi_awvalid_i,
  output logic                        s_axi_awready_o,
  input  wire logic [31:0]            s_axi_wdata_i,
  input  wire logic [3:0]             s_axi_wstrb_i,
  input  wire logic                   s_axi_wvalid_i,
  output logic                        s_axi_wready_o,
  output logic      [1:0]             s_axi_bresp_o,
  output logic                        s_axi_bvalid_o,
  input  wire logic                   s_axi_bready_i,
  input  wire logic [31:0]            s_axi_araddr_i,
  input  wire logic                   s_axi_arvalid_i,
  output logic                        s_axi_arready_o,
  output logic      [31:0]            s_axi_rdata_o,
  output logic      [1:0]             s_axi_rresp_o,
  output logic                        s_axi_rvalid_o,
  input  wire logic                   s_axi_rready_i,
  output logic      [ABG_EXT_NUM-1:0] ext_bus_ground_en_o,
  output logic      [ABG_INT_NUM-1:0] int_bus_ground_en_o
);

  abg_reg_if regif ();

  // write channel
  abg_wr_state_t wst_r;
  abg_wr_state_t wst_nxt;
  logic          aw_got_r;
  logic          aw_got_nxt;
  logic          w_got_r;
  logic          w_got_nxt;
  logic [31:0]   awaddr_r;
  logic [31:0]   awaddr_nxt;
  logic [31:0]   wdata_r;
  logic [31:0]   wdata_nxt;
  logic [3:0]    wstrb_r;
  logic [3:0]    wstrb_nxt;
  logic          awready_nxt;
  logic          wready_nxt;
  logic          bvalid_nxt;
  logic [1:0]    bresp_nxt;
  logic          wr_go;
  logic          wr_hit;
  logic [31:0]   wr_addr;
  logic          aw_hs;
  logic          w_hs;

  assign aw_hs  = s_axi_awvalid_i && s_axi_awready_o;
  assign w_hs   = s_axi_wvalid_i && s_axi_wready_o;
  // address of the commit cycle, straight from the pins when it arrives last,
  // so the decode does not loop back through the next-state logic
  assign wr_addr = aw_hs ? s_axi_awaddr_i : awaddr_r;
  assign wr_hit  = (wr_addr[31:ABG_WORD_LSB] == ABG_GROUND_ADDR[31:ABG_WORD_LSB]);

  // address and data may arrive in either order; the write commits in the
  // cycle the second of them is taken, so the register and bvalid change
  // together at the same edge
  always_comb begin
    wst_nxt     = wst_r;
    aw_got_nxt  = aw_got_r;
    w_got_nxt   = w_got_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    awready_nxt = s_axi_awready_o;
    wready_nxt  = s_axi_wready_o;
    bvalid_nxt  = s_axi_bvalid_o;
    bresp_nxt   = s_axi_bresp_o;
    wr_go       = 1'b0;
    unique case (wst_r)
      WR_IDLE: begin
        if (aw_hs) begin
          aw_got_nxt  = 1'b1;
          awaddr_nxt  = s_axi_awaddr_i;
          awready_nxt = 1'b0;
        end
        if (w_hs) begin
          w_got_nxt  = 1'b1;
          wdata_nxt  = s_axi_wdata_i;
          wstrb_nxt  = s_axi_wstrb_i;
          wready_nxt = 1'b0;
        end
        if (aw_got_nxt && w_got_nxt) begin
          wr_go       = 1'b1;
          aw_got_nxt  = 1'b0;
          w_got_nxt   = 1'b0;
          awready_nxt = 1'b0;
          wready_nxt  = 1'b0;
          bvalid_nxt  = 1'b1;
          bresp_nxt   = wr_hit ? ABG_RESP_OKAY : ABG_RESP_DECERR;
          wst_nxt     = WR_RESP;
        end
      end
      WR_RESP: begin
        if (s_axi_bready_i) begin
          bvalid_nxt  = 1'b0;
          awready_nxt = 1'b1;
          wready_nxt  = 1'b1;
          wst_nxt     = WR_IDLE;
        end
      end
      default: begin
        aw_got_nxt  = 1'b0;
        w_got_nxt   = 1'b0;
        bvalid_nxt  = 1'b0;
        awready_nxt = 1'b1;
        wready_nxt  = 1'b1;
        wst_nxt     = WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wst_r           <= WR_IDLE;
      aw_got_r        <= 1'b0;
      w_got_r         <= 1'b0;
      awaddr_r        <= 32'h0000_0000;
      wdata_r         <= 32'h0000_0000;
      wstrb_r         <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= ABG_RESP_OKAY;
    end else begin
      wst_r           <= wst_nxt;
      aw_got_r        <= aw_got_nxt;
      w_got_r         <= w_got_nxt;
      awaddr_r        <= awaddr_nxt;
      wdata_r         <= wdata_nxt;
      wstrb_r         <= wstrb_nxt;
      s_axi_awready_o <= awready_nxt;
      s_axi_wready_o  <= wready_nxt;
      s_axi_bvalid_o  <= bvalid_nxt;
      s_axi_bresp_o   <= bresp_nxt;
    end
  end

  // an unmapped write is answered but never reaches the bank
  assign regif.wr_en   = wr_go && wr_hit;
  assign regif.wr_data = wdata_nxt;
  assign regif.wr_strb = wstrb_nxt;

  // read channel
  abg_rd_state_t rst_st_r;
  abg_rd_state_t rst_st_nxt;
  logic          arready_nxt;
  logic          rvalid_nxt;
  logic [31:0]   rdata_nxt;
  logic [1:0]    rresp_nxt;
  logic          ar_hs;
  logic          rd_hit;

  assign ar_hs  = s_axi_arvalid_i && s_axi_arready_o;
  assign rd_hit = (s_axi_araddr_i[31:ABG_WORD_LSB] == ABG_GROUND_ADDR[31:ABG_WORD_LSB]);

  always_comb begin
    rst_st_nxt  = rst_st_r;
    arready_nxt = s_axi_arready_o;
    rvalid_nxt  = s_axi_rvalid_o;
    rdata_nxt   = s_axi_rdata_o;
    rresp_nxt   = s_axi_rresp_o;
    unique case (rst_st_r)
      RD_IDLE: begin
        if (ar_hs) begin
          arready_nxt = 1'b0;
          rvalid_nxt  = 1'b1;
          if (rd_hit) begin
            rdata_nxt = {ABG_RSVD_VAL, regif.ground};
            rresp_nxt = ABG_RESP_OKAY;
          end else begin
            rdata_nxt = 32'h0000_0000;
            rresp_nxt = ABG_RESP_DECERR;
          end
          rst_st_nxt = RD_RESP;
        end
      end
      RD_RESP: begin
        if (s_axi_rready_i) begin
          rvalid_nxt  = 1'b0;
          arready_nxt = 1'b1;
          rst_st_nxt  = RD_IDLE;
        end
      end
      default: begin
        rvalid_nxt  = 1'b0;
        arready_nxt = 1'b1;
        rst_st_nxt  = RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rst_st_r        <= RD_IDLE;
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= ABG_RESP_OKAY;
    end else begin
      rst_st_r        <= rst_st_nxt;
      s_axi_arready_o <= arready_nxt;
      s_axi_rvalid_o  <= rvalid_nxt;
      s_axi_rdata_o   <= rdata_nxt;
      s_axi_rresp_o   <= rresp_nxt;
    end
  end

  // storage and switch drive
  abg_ground_bank u_bank (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .regif     (regif)
  );

  // the extra flop stage delays switch changes by one cycle after the write
  abg_switch_drv u_drv (
    .sys_clk_i           (sys_clk_i),
    .rst_i               (rst_i),
    .regif               (regif),
    .ext_bus_ground_en_o (ext_bus_ground_en_o),
    .int_bus_ground_en_o (int_bus_ground_en_o)
  );

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  reset_all_grounded_a: assert property (
    $past(rst_i) |-> (regif.ground == ABG_GROUND_RST) ##1
      (ext_bus_ground_en_o == ABG_EXT_RST && int_bus_ground_en_o == ABG_INT_RST))
    else $error("buses not all grounded after reset");

  ext_switch_map_a: assert property (
    ##1 ext_bus_ground_en_o == $past(regif.ground[ABG_EXT_LSB +: ABG_EXT_NUM]))
    else $error("external ground enable does not follow its bit");

  int_switch_map_a: assert property (
    ##1 int_bus_ground_en_o == $past(regif.ground[ABG_INT_LSB +: ABG_INT_NUM]))
    else $error("internal ground enable does not follow its bit");

  full_write_lands_a: assert property (
    (regif.wr_en && regif.wr_strb == 4'hf) |=>
      regif.ground == $past(regif.wr_data[ABG_IMPL_BITS-1:0]) ##1
      ext_bus_ground_en_o == $past(regif.wr_data[ABG_EXT_NUM-1:0], 2))
    else $error("written grounding value not applied");

  miss_write_kept_a: assert property (
    (wr_go && !wr_hit) |=> $stable(regif.ground) && s_axi_bresp_o == ABG_RESP_DECERR)
    else $error("unmapped write changed the register");

  no_write_hold_a: assert property (
    !regif.wr_en |=> $stable(regif.ground))
    else $error("register changed without a write");

  strobe_keep_a: assert property (
    (regif.wr_en && !regif.wr_strb[0]) |=> $stable(regif.ground[7:0]))
    else $error("strobe-off byte was overwritten");

  write_answer_a: assert property (
    wr_go |=> s_axi_bvalid_o && !s_axi_awready_o && !s_axi_wready_o)
    else $error("write response missing after commit");

  bresp_hold_a: assert property (
    (s_axi_bvalid_o && !s_axi_bready_i) |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped before bready");

  read_value_a: assert property (
    (ar_hs && rd_hit) |=> s_axi_rvalid_o && s_axi_rresp_o == ABG_RESP_OKAY &&
      s_axi_rdata_o == {ABG_RSVD_VAL, $past(regif.ground)})
    else $error("read data does not show the register");

  reserved_zero_a: assert property (
    s_axi_rvalid_o |-> s_axi_rdata_o[31:ABG_IMPL_BITS] == ABG_RSVD_VAL)
    else $error("reserved bits read nonzero");

  rdata_hold_a: assert property (
    (s_axi_rvalid_o && !s_axi_rready_i) |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped before rready");

  write_open_cov_c: cover property (
    (regif.wr_en && !regif.wr_data[ABG_INT_LSB]) ##2 !int_bus_ground_en_o[0]);

  split_order_cov_c: cover property (
    (w_hs && !aw_hs) ##[1:4] aw_hs ##1 s_axi_bvalid_o);

  read_miss_cov_c: cover property (
    (ar_hs && !rd_hit) ##1 s_axi_rresp_o == ABG_RESP_DECERR);

  late_bready_cov_c: cover property (
    (s_axi_bvalid_o && !s_axi_bready_i) ##1 (s_axi_bvalid_o && s_axi_bready_i));

endmodule : abg_ground_ctrl

`default_nettype wire

// >>> design/abg_pkg.sv
`default_nettype none

package abg_pkg;

  // register map, byte address of the one grounding word
  localparam logic [31:0] ABG_GROUND_ADDR = 32'h0400_4408;
  localparam int          ABG_WORD_LSB    = 2;

  // field layout of the grounding word
  localparam int ABG_EXT_LSB   = 0;
  localparam int ABG_EXT_NUM   = 12;
  localparam int ABG_INT_LSB   = 12;
  localparam int ABG_INT_NUM   = 16;
  localparam int ABG_IMPL_BITS = 28;
  localparam int ABG_RSVD_BITS = 4;

  // every implemented bit comes out of reset grounded
  localparam logic [ABG_IMPL_BITS-1:0] ABG_GROUND_RST = 28'hfff_ffff;
  localparam logic [ABG_EXT_NUM-1:0]   ABG_EXT_RST    = 12'hfff;
  localparam logic [ABG_INT_NUM-1:0]   ABG_INT_RST    = 16'hffff;
  localparam logic [ABG_RSVD_BITS-1:0] ABG_RSVD_VAL   = 4'h0;

  // axi responses
  localparam logic [1:0] ABG_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ABG_RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    WR_IDLE = 2'h1,
    WR_RESP = 2'h2
  } abg_wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h1,
    RD_RESP = 2'h2
  } abg_rd_state_t;

endpackage : abg_pkg

`default_nettype wire

// >>> design/abg_reg_if.sv
`default_nettype none

interface abg_reg_if;
  import abg_pkg::*;

  logic                     wr_en;
  logic [31:0]              wr_data;
  logic [3:0]               wr_strb;
  logic [ABG_IMPL_BITS-1:0] ground;

  modport ctrl (output wr_en, output wr_data, output wr_strb, input ground);
  modport bank (input wr_en, input wr_data, input wr_strb, output ground);
  modport drv  (input ground);

endinterface : abg_reg_if

`default_nettype wire

// >>> design/abg_ground_bank.sv
`default_nettype none

module abg_ground_bank
  import abg_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  abg_reg_if.bank   regif
);

  logic [ABG_IMPL_BITS-1:0] ground_r;
  logic [ABG_IMPL_BITS-1:0] ground_nxt;

  // one flop per switch, each lane written only under its byte strobe
  genvar b;
  for (b = 0; b < ABG_IMPL_BITS; b++) begin : g_bit
    always_comb begin
      ground_nxt[b] = ground_r[b];
      if (regif.wr_en && regif.wr_strb[b/8]) begin
        ground_nxt[b] = regif.wr_data[b];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ground_r <= ABG_GROUND_RST;
    end else begin
      ground_r <= ground_nxt;
    end
  end

  assign regif.ground = ground_r;

endmodule : abg_ground_bank

`default_nettype wire

// >>> design/abg_switch_drv.sv
`default_nettype none

module abg_switch_drv
  import abg_pkg::*;
(
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  abg_reg_if.drv                      regif,
  output logic      [ABG_EXT_NUM-1:0] ext_bus_ground_en_o,
  output logic      [ABG_INT_NUM-1:0] int_bus_ground_en_o
);

  logic [ABG_EXT_NUM-1:0] ext_nxt;
  logic [ABG_INT_NUM-1:0] int_nxt;

  // retimed so the switch enables leave the block from flops
  always_comb begin
    ext_nxt = regif.ground[ABG_EXT_LSB +: ABG_EXT_NUM];
    int_nxt = regif.ground[ABG_INT_LSB +: ABG_INT_NUM];
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ext_bus_ground_en_o <= ABG_EXT_RST;
      int_bus_ground_en_o <= ABG_INT_RST;
    end else begin
      ext_bus_ground_en_o <= ext_nxt;
      int_bus_ground_en_o <= int_nxt;
    end
  end

endmodule : abg_switch_drv

`default_nettype wire

// >>> test/abg_ground_ctrl_bench.sv
`default_nettype none

module abg_ground_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import abg_pkg::*;

  logic                   sys_clk;
  logic                   rst;
  logic [31:0]            awaddr, wdata, araddr, rdata, word;
  logic [3:0]             wstrb;
  logic                   awvalid, wvalid, bready, arvalid, rready;
  logic                   awready, wready, bvalid, arready, rvalid;
  logic [1:0]             bresp, rresp, resp;
  logic [ABG_EXT_NUM-1:0] ext_en;
  logic [ABG_INT_NUM-1:0] int_en;
  int                     err_count, comparisons;
  int                     ready_lag;

  abg_ground_ctrl DUT (
    .sys_clk_i           (sys_clk),
    .rst_i               (rst),
    .s_axi_awaddr_i      (awaddr),
    .s_axi_awvalid_i     (awvalid),
    .s_axi_awready_o     (awready),
    .s_axi_wdata_i       (wdata),
    .s_axi_wstrb_i       (wstrb),
    .s_axi_wvalid_i      (wvalid),
    .s_axi_wready_o      (wready),
    .s_axi_bresp_o       (bresp),
    .s_axi_bvalid_o      (bvalid),
    .s_axi_bready_i      (bready),
    .s_axi_araddr_i      (araddr),
    .s_axi_arvalid_i     (arvalid),
    .s_axi_arready_o     (arready),
    .s_axi_rdata_o       (rdata),
    .s_axi_rresp_o       (rresp),
    .s_axi_rvalid_o      (rvalid),
    .s_axi_rready_i      (rready),
    .ext_bus_ground_en_o (ext_en),
    .int_bus_ground_en_o (int_en)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // payload is held until each channel's own ready is seen at the sampling edge
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    bit aw_p;
    bit w_p;
    bit got;
    int n;
    aw_p = 1'b1;
    w_p = 1'b1;
    got = 1'b0;
    n = 0;
    r = 2'h0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (ready_lag == 0);
    while ((aw_p || w_p) && n < 50) begin
      @(negedge sys_clk);
      if (awready === 1'b1) aw_p = 1'b0;
      if (wready === 1'b1) w_p = 1'b0;
      @(posedge sys_clk);
      awvalid <= aw_p;
      wvalid <= w_p;
      n++;
    end
    // a late bready leaves the response waiting, and it must stand meanwhile
    if (ready_lag > 0) begin
      repeat (ready_lag) @(posedge sys_clk);
      bready <= 1'b1;
    end
    while (!got && n < 100) begin
      @(negedge sys_clk);
      got = (bvalid === 1'b1) && (bready === 1'b1);
      r = bresp;
      @(posedge sys_clk);
      n++;
    end
    bready <= 1'b0;
    check("write done", 32'h0000_0001, {31'h0, got});
    @(posedge sys_clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar_p;
    bit got;
    int n;
    ar_p = 1'b1;
    got = 1'b0;
    n = 0;
    d = 32'h0;
    r = 2'h0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (ready_lag == 0);
    while (ar_p && n < 50) begin
      @(negedge sys_clk);
      if (arready === 1'b1) ar_p = 1'b0;
      @(posedge sys_clk);
      arvalid <= ar_p;
      n++;
    end
    if (ready_lag > 0) begin
      repeat (ready_lag) @(posedge sys_clk);
      rready <= 1'b1;
    end
    while (!got && n < 100) begin
      @(negedge sys_clk);
      got = (rvalid === 1'b1) && (rready === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge sys_clk);
      n++;
    end
    rready <= 1'b0;
    check("read done", 32'h0000_0001, {31'h0, got});
    @(posedge sys_clk);
  endtask : axi_rd

  // register readback first, so the switch outputs have long since followed it
  task automatic expect_reg(input logic [31:0] e);
    axi_rd(ABG_GROUND_ADDR, word, resp);
    check("rdata", e, word);
    check("rresp", {30'h0, ABG_RESP_OKAY}, {30'h0, resp});
    check("ext", {20'h0_0000, e[11:0]}, {20'h0_0000, ext_en});
    check("int", {16'h0000, e[27:12]}, {16'h0000, int_en});
  endtask : expect_reg

  task automatic t_walk;
    for (int i = 0; i < 28; i++) begin
      axi_wr(ABG_GROUND_ADDR, 32'h0000_0001 << i, 4'hf, resp);
      check("bresp", {30'h0, ABG_RESP_OKAY}, {30'h0, resp});
      expect_reg(32'h0000_0001 << i);
    end
  endtask : t_walk

  task automatic t_strobe;
    axi_wr(ABG_GROUND_ADDR, 32'hffff_ffff, 4'hf, resp);
    expect_reg(32'h0fff_ffff);
    axi_wr(ABG_GROUND_ADDR, 32'h0000_0000, 4'h5, resp);
    expect_reg(32'h0f00_ff00);
    axi_wr(ABG_GROUND_ADDR, 32'h5a5a_5a5a, 4'ha, resp);
    expect_reg(32'h0a00_5a00);
  endtask : t_strobe

  task automatic t_unmapped;
    axi_wr(ABG_GROUND_ADDR + 32'h0000_0004, 32'h0000_0000, 4'hf, resp);
    check("bresp", {30'h0, ABG_RESP_DECERR}, {30'h0, resp});
    axi_rd(ABG_GROUND_ADDR + 32'h0000_0004, word, resp);
    check("rresp", {30'h0, ABG_RESP_DECERR}, {30'h0, resp});
    check("rdata", 32'h0000_0000, word);
    expect_reg(32'h0a00_5a00);
  endtask : t_unmapped

  // slow bready and rready: both answers must stand until they are taken
  task automatic t_late;
    ready_lag = 3;
    axi_wr(ABG_GROUND_ADDR, 32'h0123_4567, 4'hf, resp);
    check("bresp", {30'h0, ABG_RESP_OKAY}, {30'h0, resp});
    expect_reg(32'h0123_4567);
    ready_lag = 0;
  endtask : t_late

  // a second reset in mid-run must ground every bus again
  task automatic t_rereset;
    axi_wr(ABG_GROUND_ADDR, 32'h0000_0000, 4'hf, resp);
    rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    check("ext", 32'h0000_0fff, {20'h0_0000, ext_en});
    check("int", 32'h0000_ffff, {16'h0000, int_en});
    @(posedge sys_clk);
    rst <= 1'b0;
    expect_reg(32'h0fff_ffff);
  endtask : t_rereset

  task automatic test_done;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  initial begin
    err_count = 0;
    comparisons = 0;
    ready_lag = 0;
    rst <= 1'b1;
    awaddr <= 32'h0;
    wdata <= 32'h0;
    araddr <= 32'h0;
    wstrb <= 4'h0;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    arvalid <= 1'b0;
    rready <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    expect_reg(32'h0fff_ffff);
    t_walk;
    t_strobe;
    t_unmapped;
    t_late;
    t_rereset;
    test_done;
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    err_count++;
    test_done;
  end

endmodule : abg_ground_ctrl_bench

`default_nettype wire
